// *** core/resistance_ratio_thermostat.sv ***
// Two-resistor ratio thermostat controller with measuring indicator
`timescale 1ns/1ps
module resistance_ratio_thermostat #(
    parameter longint unsigned PERIOD_CYC = thermostat_pkg::PERIOD_CYC,
    parameter longint unsigned FAST_PERIOD_CYC =
        thermostat_pkg::FAST_PERIOD_CYC,
    parameter longint unsigned BUSY_CYC = thermostat_pkg::BUSY_CYC,
    parameter longint unsigned BLINK_CYC = thermostat_pkg::BLINK_CYC,
    parameter int unsigned TIMEOUT_CYC = 1 << (thermostat_pkg::TIME_W - 1)
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Capacitor comparator level, asynchronous
    input wire logic cap_high_i,
    // Resistor and capacitor network drive
    output thermostat_pkg::cap_drive_t cap_o,
    // Results
    output logic measuring_indicator_o,
    output logic control_o
);
    localparam int W = thermostat_pkg::TIME_W;

    initial begin
        // Interval counters are 32 bits; wider values would wrap
        if (BUSY_CYC < 64 || PERIOD_CYC <= BUSY_CYC ||
            FAST_PERIOD_CYC <= BUSY_CYC || BLINK_CYC == 0 ||
            PERIOD_CYC > 64'hFFFF_FFFF || FAST_PERIOD_CYC > 64'hFFFF_FFFF ||
            BLINK_CYC > 64'hFFFF_FFFF ||
            TIMEOUT_CYC >= (1 << W) || TIMEOUT_CYC < 4)
            $error("resistance_ratio_thermostat: bad timing parameters");
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DIS_P = 6'h02,
        ST_CHG_P = 6'h04,
        ST_DIS_R = 6'h08,
        ST_CHG_R = 6'h10,
        ST_DECIDE = 6'h20
    } state_t;

    // Power-on reset: a flop with no reset powers up cleared
    logic [3:0] por_cnt = 4'h0;
    logic por_done;
    assign por_done = por_cnt == 4'hF;
    always_ff @(posedge core_clk_i) begin
        if (!por_done) por_cnt <= por_cnt + 4'h1;
    end

    // Reset pin passes three flops; a change counts when two agree
    logic [2:0] rst_sync;
    logic rst_filt;
    always_ff @(posedge core_clk_i) begin
        rst_sync <= {rst_sync[1:0], reset_n_i};
        if (rst_sync[2] == rst_sync[1]) rst_filt <= rst_sync[1];
    end
    // Only the filtered copy resets: the raw pin could meet a flop
    // mid-edge and reset some flops but not others
    logic rst_n;
    assign rst_n = rst_filt & por_done;

    logic [2:0] cap_sync;
    logic cap_high;
    always_ff @(posedge core_clk_i) begin
        cap_sync <= {cap_sync[1:0], cap_high_i};
        if (!rst_n) cap_high <= 1'b0;
        else if (cap_sync[2] == cap_sync[1]) cap_high <= cap_sync[1];
    end

    state_t state;
    state_t next_state;
    logic [31:0] wait_cnt;
    logic [W-1:0] phase_cnt;
    logic [W-1:0] primary_time;
    logic fault;
    logic fast;
    logic [1:0] agree;
    logic [31:0] busy_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    thermostat_pkg::result_t res;

    // Capacitor phases: discharge low, then charge through one resistor
    wire in_dis = (state == ST_DIS_P) || (state == ST_DIS_R);
    wire in_chg = (state == ST_CHG_P) || (state == ST_CHG_R);
    wire timeout = phase_cnt == W'(TIMEOUT_CYC);
    wire phase_end = in_dis ? !cap_high : cap_high;
    wire [31:0] period = fast ? 32'(FAST_PERIOD_CYC) : 32'(PERIOD_CYC);
    wire start = (state == ST_IDLE) && (wait_cnt >= period - 32'h1);
    // High from the start edge, so the indicator rises with the drive
    wire busy_now = start || (state != ST_IDLE);

    // Primary larger trips on; release needs the margin below reference
    wire [W+8:0] ref_scaled = {9'h0, res.reference_time} * 33'(
        thermostat_pkg::HYST_NUM);
    wire [W-1:0] margin = W'(ref_scaled >> thermostat_pkg::HYST_SHIFT);
    wire above = res.primary_time > res.reference_time;
    wire below = {1'b0, res.primary_time} + {1'b0, margin} <
        {1'b0, res.reference_time};
    wire wants_change = control_o ? below : above;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start) next_state = ST_DIS_P;
            ST_DIS_P: if (phase_end || timeout) next_state = ST_CHG_P;
            ST_CHG_P: if (phase_end || timeout) next_state = ST_DIS_R;
            ST_DIS_R: if (phase_end || timeout) next_state = ST_CHG_R;
            ST_CHG_R: if (phase_end || timeout) next_state = ST_DECIDE;
            ST_DECIDE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            wait_cnt <= 32'h0;
            phase_cnt <= '0;
        end else begin
            state <= next_state;
            wait_cnt <= start ? 32'h0 : wait_cnt + 32'h1;
            phase_cnt <= (next_state != state) ? '0 : phase_cnt + W'(1);
        end
    end

    // Charge time plus discharge time through each resistor
    always_ff @(posedge core_clk_i) begin
        if (!rst_n) begin
            primary_time <= '0;
            res <= '0;
            fault <= 1'b0;
        end else begin
            if (start) begin
                primary_time <= '0;
                fault <= 1'b0;
            end else if (state == ST_DIS_P || state == ST_CHG_P) begin
                primary_time <= primary_time + W'(1);
            end
            // Hand over when the primary charge ends; its last cycle
            // counts too, so both sides see the same number of phases
            if (state == ST_CHG_P && next_state != state) begin
                res.primary_time <= primary_time + W'(1);
                res.reference_time <= '0;
            end else if (state == ST_CHG_R || state == ST_DIS_R) begin
                res.reference_time <= res.reference_time + W'(1);
            end
            if (in_chg && timeout) fault <= 1'b1;
            if (state == ST_DECIDE) res.open_fault <= fault;
        end
    end

    // Three consecutive agreeing cycles before switching
    always_ff @(posedge core_clk_i) begin
        if (!rst_n) begin
            agree <= 2'h0;
            control_o <= 1'b0;
            fast <= 1'b0;
        end else if (state == ST_DECIDE) begin
            fast <= fault || wants_change;
            if (fault || !wants_change) begin
                agree <= 2'h0;
            end else if (agree == thermostat_pkg::AGREE_COUNT - 2'h1) begin
                agree <= 2'h0;
                control_o <= !control_o;
            end else begin
                agree <= agree + 2'h1;
            end
        end
    end

    // Busy stretches to the nominal length so the pulse is visible
    always_ff @(posedge core_clk_i) begin
        if (!rst_n) begin
            busy_cnt <= 32'h0;
            blink_cnt <= 32'h0;
            blink <= 1'b0;
            measuring_indicator_o <= 1'b0;
        end else begin
            if (start) busy_cnt <= 32'(BUSY_CYC);
            else if (busy_cnt != 32'h0) busy_cnt <= busy_cnt - 32'h1;
            if (blink_cnt >= 32'(BLINK_CYC) - 32'h1) begin
                blink_cnt <= 32'h0;
                blink <= !blink;
            end else begin
                blink_cnt <= blink_cnt + 32'h1;
            end
            // Measuring always shows high; the warning blinks between
            if (res.open_fault && !busy_now)
                measuring_indicator_o <= blink;
            else
                measuring_indicator_o <= busy_now ||
                    (busy_cnt != 32'h0);
        end
    end

    // Discharge pulls the capacitor low; charge drives it high
    always_ff @(posedge core_clk_i) begin
        if (!rst_n) begin
            cap_o <= '0;
        end else begin
            cap_o.cap_drive <= (next_state != ST_IDLE) &&
                (next_state != ST_DECIDE);
            cap_o.cap_level <= next_state == ST_CHG_P ||
                next_state == ST_CHG_R;
            cap_o.primary_en <= next_state == ST_DIS_P ||
                next_state == ST_CHG_P;
            cap_o.reference_en <= next_state == ST_DIS_R ||
                next_state == ST_CHG_R;
        end
    end
endmodule : resistance_ratio_thermostat

// *** core/thermostat_pkg.sv ***
// Package with timing constants and carried types for the thermostat
package thermostat_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    // Measurement interval and busy time in their own units
    localparam int unsigned PERIOD_MS = 2000;
    localparam int unsigned FAST_PERIOD_MS = 500;
    localparam int unsigned BUSY_MS = 25;
    localparam int unsigned BLINK_MS = 50;
    localparam longint unsigned PERIOD_CYC =
        longint'(PERIOD_MS) * CLK_HZ / 1000;
    localparam longint unsigned FAST_PERIOD_CYC =
        longint'(FAST_PERIOD_MS) * CLK_HZ / 1000;
    localparam longint unsigned BUSY_CYC = longint'(BUSY_MS) * CLK_HZ / 1000;
    localparam longint unsigned BLINK_CYC =
        longint'(BLINK_MS) * CLK_HZ / 1000;
    // Agreeing cycles before the output may change
    localparam logic [1:0] AGREE_COUNT = 2'h3;
    // Release margin: about 8 percent, as 21/256 of the reference time
    localparam int unsigned HYST_NUM = 21;
    localparam int unsigned HYST_SHIFT = 8;
    localparam int unsigned TIME_W = 24;

    // Capacitor network drive
    typedef struct packed {
        logic cap_drive;
        logic cap_level;
        logic primary_en;
        logic reference_en;
    } cap_drive_t;

    // Timings of one measurement cycle
    typedef struct packed {
        logic [TIME_W-1:0] primary_time;
        logic [TIME_W-1:0] reference_time;
        logic open_fault;
    } result_t;
endpackage : thermostat_pkg

// *** test/thermostat_sva.sv ***
// Port-level checks for the ratio thermostat
`timescale 1ns/1ps
module thermostat_sva #(
    parameter longint unsigned PERIOD_CYC = 2000,
    parameter longint unsigned FAST_PERIOD_CYC = 1000
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic cap_high_i,
    input wire thermostat_pkg::cap_drive_t cap_o,
    input wire logic measuring_indicator_o,
    input wire logic control_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Cycles since the last measurement start; slack covers reset sync
    longint unsigned gap;
    always_ff @(posedge core_clk_i) begin
        gap <= (!reset_n_i || $rose(cap_o.cap_drive)) ? 0 : gap + 1;
    end
    AST_ONE_RES: assert property (cap_o.cap_drive |->
        !(cap_o.primary_en && cap_o.reference_en)) else $error("two paths");
    AST_START: assert property ($rose(cap_o.cap_drive) |->
        measuring_indicator_o && cap_o.primary_en && !cap_o.cap_level)
        else $error("bad start");
    AST_BUSY_MIN: assert property ($rose(measuring_indicator_o) |->
        measuring_indicator_o[*8]) else $error("short busy");
    AST_PERIOD: assert property ($rose(cap_o.cap_drive) |->
        gap >= FAST_PERIOD_CYC - 4 && gap <= PERIOD_CYC + 24)
        else $error("bad interval");
    AST_DRIVE_END: assert property ($rose(cap_o.cap_drive) |->
        ##[1:900] !cap_o.cap_drive) else $error("endless drive");
    AST_CTL_BUSY: assert property ($changed(control_o) |->
        measuring_indicator_o) else $error("output moved while idle");
    AST_CTL_HOLD: assert property ($changed(control_o) |=>
        $stable(control_o)[*8]) else $error("output chatter");
    AST_RESET_LOW: assert property ($rose(reset_n_i) |->
        !control_o && !measuring_indicator_o && !cap_o.cap_drive)
        else $error("outputs live in reset");
endmodule : thermostat_sva

// *** test/rc_network_model.sv ***
// Behavioural resistor and capacitor network with comparator
`timescale 1ns/1ps
module rc_network_model (
    // Clock
    input wire logic core_clk_i,
    // Network drive, resistances in cycles, open fault
    input wire thermostat_pkg::cap_drive_t cap_i,
    input wire logic [7:0] primary_res_i,
    input wire logic [7:0] reference_res_i,
    input wire logic open_i,
    // Comparator
    output logic cap_high_o
);
    logic [7:0] steps = 8'h00;
    logic [1:0] phase = 2'h0;
    logic cap_high = 1'b0;
    wire [1:0] now = {cap_i.cap_drive, cap_i.cap_level};
    wire [7:0] res = cap_i.primary_en ? primary_res_i : reference_res_i;
    // Steps left from the previous phase must not end this one
    wire settled = cap_i.cap_drive && (phase == now) && (steps >= res);
    assign cap_high_o = cap_high;
    always @(posedge core_clk_i) begin
        phase <= now;
        steps <= (phase != now) ? 8'h00 : steps + 8'h01;
        // An open input never lets the cap charge past threshold
        if (settled && !(open_i && cap_i.cap_level)) begin
            cap_high <= cap_i.cap_level;
        end
    end
endmodule : rc_network_model

// *** test/resistance_ratio_thermostat_tb.sv ***
// Self-checking bench for the ratio thermostat
`timescale 1ns/1ps
module resistance_ratio_thermostat_tb;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cap_high_i;
    thermostat_pkg::cap_drive_t cap_o;
    logic measuring_indicator_o;
    logic control_o;
    logic [7:0] rp = 8'h30;
    logic [7:0] rr = 8'h30;
    logic open_in = 1'b0;
    logic ctl = 1'b0;
    logic last;
    int agree = 0;
    int errors = 0;
    int checks = 0;
    int edges;
    logic [1:0] cls [12] = '{0, 0, 1, 0, 0, 0, 1, 1, 2, 1, 1, 1};
    always #2.5 core_clk_i = ~core_clk_i;
    resistance_ratio_thermostat #(.PERIOD_CYC(2000), .FAST_PERIOD_CYC(1000),
        .BUSY_CYC(100), .BLINK_CYC(10), .TIMEOUT_CYC(200)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .cap_high_i(cap_high_i), .cap_o(cap_o),
        .measuring_indicator_o(measuring_indicator_o), .control_o(control_o));
    rc_network_model net (.core_clk_i(core_clk_i), .cap_i(cap_o),
        .primary_res_i(rp), .reference_res_i(rr), .open_i(open_in),
        .cap_high_o(cap_high_i));
    // Change wanted: switch on if primary larger, off below margin
    function automatic logic wants(logic on, logic [7:0] p, logic [7:0] r);
        wants = on ? ((32'(p) << thermostat_pkg::HYST_SHIFT) +
            32'(r) * thermostat_pkg::HYST_NUM <
            (32'(r) << thermostat_pkg::HYST_SHIFT)) : (p > r);
    endfunction : wants
    task automatic test_done;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic check_bit(logic got, logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit
    task automatic wait_ind(logic lvl);
        int n;
        n = 0;
        while (measuring_indicator_o !== lvl && n < 3000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            test_done();
        end
    endtask : wait_ind
    // Downstream view: result sampled once the indicator has fallen
    task automatic one_cycle(logic [1:0] c, logic [7:0] r);
        logic [7:0] p;
        p = (c == 0) ? r + 8'h14 : (c == 1) ? r >> 1 : r - 8'h02;
        @(posedge core_clk_i);
        rp <= p;
        rr <= r;
        wait_ind(1'b1);
        wait_ind(1'b0);
        agree = wants(ctl, p, r) ? agree + 1 : 0;
        if (agree == 3) begin
            ctl = ~ctl;
            agree = 0;
        end
        check_bit(control_o, ctl);
    endtask : one_cycle
    initial begin
        void'($urandom(93));
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        check_bit(control_o, 1'b0);
        check_bit(measuring_indicator_o, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            one_cycle(i < 12 ? cls[i] : 2'($urandom % 3),
                8'(40 + $urandom % 30));
        end
        $display("test hysteresis done");
        @(posedge core_clk_i);
        open_in <= 1'b1;
        wait_ind(1'b1);
        edges = 0;
        last = 1'b1;
        repeat (1500) begin
            @(negedge core_clk_i);
            edges += (measuring_indicator_o !== last);
            last = measuring_indicator_o;
        end
        check_bit(edges > 8, 1'b1);
        $display("test open input done");
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        open_in <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        check_bit(control_o, 1'b0);
        ctl = 1'b0;
        agree = 0;
        one_cycle(2'h0, 8'h30);
        $display("test mid reset done");
        test_done();
    end
endmodule : resistance_ratio_thermostat_tb
bind resistance_ratio_thermostat thermostat_sva #(
    .PERIOD_CYC(PERIOD_CYC), .FAST_PERIOD_CYC(FAST_PERIOD_CYC)) chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cap_high_i(cap_high_i),
    .cap_o(cap_o), .measuring_indicator_o(measuring_indicator_o),
    .control_o(control_o));
